// ==== rtl/rstp_pkg.sv ====
// Constants for the reset-strap test-point port.
// Assumes a single 40 MHz core clock and a synchronous active-low reset.
package rstp_pkg;
	localparam int RSTP_CLK_MHZ_X10 = 400;
	// Capture delay after reset release, in ns
	localparam int RSTP_CAPTURE_NS = 1500;
	localparam int RSTP_CAPTURE_CYC_I = (RSTP_CAPTURE_NS * RSTP_CLK_MHZ_X10 + 9999) / 10000;
	localparam int RSTP_CNT_W = 7;
	localparam logic [RSTP_CNT_W-1:0] RSTP_CAPTURE_CYC = RSTP_CAPTURE_CYC_I[RSTP_CNT_W-1:0];
	localparam int RSTP_TP_W = 8;
	localparam int RSTP_SEL_W = 3;
	localparam int RSTP_DIV_W = 4;
	localparam logic [RSTP_SEL_W-1:0] RSTP_SEL_HIZ = 3'h7;
	localparam logic [RSTP_SEL_W-1:0] RSTP_SEL_CLK = 3'h2;
	localparam logic [RSTP_TP_W-1:0] RSTP_TP_ALL_OFF = 8'hFF;
	localparam logic [RSTP_TP_W-1:0] RSTP_TP_ALL_ON = 8'h00;
	localparam logic [RSTP_SEL_W-1:0] RSTP_SEL_ALL_OFF = 3'h7;
	localparam logic [RSTP_SEL_W-1:0] RSTP_SEL_ALL_ON = 3'h0;
	// Divider tap per test point; 4'hF marks a point held low
	localparam logic [3:0] RSTP_TAP_LOW = 4'hF;
	localparam logic [31:0] RSTP_TAP_MAP = {4'hF, 4'hF, 4'h0, 4'h2, 4'hF, 4'h3, 4'h1, 4'h0};
	typedef enum logic [1:0] {
		RSTP_ST_WAIT = 2'h1,
		RSTP_ST_RUN = 2'h2
	} rstp_state_t;
endpackage : rstp_pkg

// ==== rtl/rstp_clk_div.sv ====
// Binary divider giving the debug clock outputs at ratios 8:4:2:1.
// Assumes the core clock and synchronous reset of the parent.
`timescale 1ns/1ps
`default_nettype none
module rstp_clk_div
	import rstp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	output logic [RSTP_DIV_W-1:0] div_taps
);
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			div_taps <= 4'h0;
		end else begin
			div_taps <= div_taps + 4'h1;
		end
	end
endmodule : rstp_clk_div
`default_nettype wire

// ==== rtl/rstp_port.sv ====
// Reset-strap test-point port: samples straps after reset, then drives debug outputs.
// Assumes pins resolved outside from out/oe_n; oe_n low means driving.
//
// Behaviour
// - Test points undriven while reset asserted
// - Capture test points 1.5 us after release
// - Drive test points only after capture
// - Hold captured levels as configuration straps
// - Capture selector pins, then drive them
// - Captured selector picks test-point output behaviour
// - Selector x111 leaves test points undriven
// - Selector x010 drives divided debug clocks
// - Software may override selection only after capture
`timescale 1ns/1ps
`default_nettype none
module rstp_port
	import rstp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [RSTP_TP_W-1:0] debug_test_points_in,
	output logic [RSTP_TP_W-1:0] debug_test_points_out,
	output logic [RSTP_TP_W-1:0] debug_test_points_oe_n,
	input wire logic [RSTP_SEL_W-1:0] test_out_strap_selector_in,
	output logic [RSTP_SEL_W-1:0] test_out_strap_selector_out,
	output logic [RSTP_SEL_W-1:0] test_out_strap_selector_oe_n,
	input wire logic [RSTP_SEL_W-1:0] jtag_tdo,
	input wire logic sw_sel_wr,
	input wire logic [RSTP_SEL_W-1:0] sw_sel,
	output logic [RSTP_TP_W-1:0] cfg_strap,
	output logic [RSTP_SEL_W-1:0] strap_sel,
	output logic [RSTP_SEL_W-1:0] active_sel,
	output logic capture_done
);
	////////////////////////////////////////////////////////////////////////////
	logic [RSTP_TP_W-1:0] tp_meta;
	logic [RSTP_TP_W-1:0] tp_sync;
	logic [RSTP_SEL_W-1:0] sel_meta;
	logic [RSTP_SEL_W-1:0] sel_sync;
	rstp_state_t state;
	logic [RSTP_CNT_W-1:0] cnt;
	logic [RSTP_DIV_W-1:0] div_taps;
	logic [RSTP_TP_W-1:0] next_tp_out;
	logic [RSTP_TP_W-1:0] next_tp_oe_n;
	logic cap_now;

	// Tap lookup for one test point
	function automatic logic tap_level(input logic [3:0] tap, input logic [RSTP_DIV_W-1:0] taps);
		logic lvl;
		lvl = 1'b0;
		if (tap != RSTP_TAP_LOW) begin
			lvl = taps[tap[1:0]];
		end
		return lvl;
	endfunction : tap_level

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tp_meta <= 8'h00;
			tp_sync <= 8'h00;
			sel_meta <= 3'h0;
			sel_sync <= 3'h0;
		end else begin
			tp_meta <= debug_test_points_in;
			tp_sync <= tp_meta;
			sel_meta <= test_out_strap_selector_in;
			sel_sync <= sel_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Post-reset delay and capture
	assign cap_now = (state == RSTP_ST_WAIT) && (cnt == RSTP_CAPTURE_CYC - 7'h01);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state <= RSTP_ST_WAIT;
			cnt <= 7'h00;
		end else begin
			case (state)
				RSTP_ST_WAIT: begin
					cnt <= cnt + 7'h01;
					if (cap_now) begin
						state <= RSTP_ST_RUN;
					end
				end
				RSTP_ST_RUN: begin
					state <= RSTP_ST_RUN;
				end
				default: begin
					state <= RSTP_ST_WAIT;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			capture_done <= 1'b0;
			cfg_strap <= 8'h00;
			strap_sel <= RSTP_SEL_HIZ;
		end else if (cap_now) begin
			capture_done <= 1'b1;
			cfg_strap <= tp_sync;
			strap_sel <= sel_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output selection: strap default, software override
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			active_sel <= RSTP_SEL_HIZ;
		end else if (cap_now) begin
			active_sel <= sel_sync;
		end else if (capture_done && sw_sel_wr) begin
			active_sel <= sw_sel;
		end
	end

	rstp_clk_div u_div (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.div_taps(div_taps)
	);

	generate
		for (genvar i = 0; i < RSTP_TP_W; i++) begin : g_tp
			always_comb begin
				if (capture_done && active_sel == RSTP_SEL_CLK) begin
					next_tp_out[i] = tap_level(RSTP_TAP_MAP[4*i +: 4], div_taps);
					next_tp_oe_n[i] = 1'b0;
				end else begin
					next_tp_out[i] = 1'b0;
					next_tp_oe_n[i] = 1'b1;
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			debug_test_points_out <= 8'h00;
			debug_test_points_oe_n <= RSTP_TP_ALL_OFF;
		end else begin
			debug_test_points_out <= next_tp_out;
			debug_test_points_oe_n <= next_tp_oe_n;
		end
	end

	// Selector pins return to their ordinary output use after capture
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			test_out_strap_selector_out <= 3'h0;
			test_out_strap_selector_oe_n <= RSTP_SEL_ALL_OFF;
		end else begin
			test_out_strap_selector_out <= jtag_tdo;
			if (cap_now || capture_done) begin
				test_out_strap_selector_oe_n <= RSTP_SEL_ALL_ON;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	logic [RSTP_CNT_W-1:0] rel_cyc;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rel_cyc <= 7'h00;
		end else if (rel_cyc != 7'h7F) begin
			rel_cyc <= rel_cyc + 7'h01;
		end
	end

	property p_hiz_in_reset;
		@(posedge core_clk) !rst_n |=> (debug_test_points_oe_n == RSTP_TP_ALL_OFF);
	endproperty
	a_hiz_in_reset: assert property (p_hiz_in_reset) else $error("test points driven in reset");

	property p_capture_time;
		@(posedge core_clk) disable iff (!rst_n) $rose(capture_done) |-> (rel_cyc == RSTP_CAPTURE_CYC);
	endproperty
	a_capture_time: assert property (p_capture_time) else $error("capture at wrong time");

	property p_no_drive_before;
		@(posedge core_clk) disable iff (!rst_n)
			!capture_done |-> (debug_test_points_oe_n == RSTP_TP_ALL_OFF) && (test_out_strap_selector_oe_n == RSTP_SEL_ALL_OFF);
	endproperty
	a_no_drive_before: assert property (p_no_drive_before) else $error("pins driven before capture");

	property p_strap_hold;
		@(posedge core_clk) disable iff (!rst_n) capture_done && $past(capture_done) |-> $stable(cfg_strap) && $stable(strap_sel);
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("strap value changed");

	property p_sel_drive;
		@(posedge core_clk) disable iff (!rst_n) capture_done |-> (test_out_strap_selector_oe_n == RSTP_SEL_ALL_ON);
	endproperty
	a_sel_drive: assert property (p_sel_drive) else $error("selector pins not driven");

	property p_default_sel;
		@(posedge core_clk) disable iff (!rst_n) $rose(capture_done) |-> (active_sel == strap_sel);
	endproperty
	a_default_sel: assert property (p_default_sel) else $error("selector default wrong");

	property p_hiz_mode;
		@(posedge core_clk) disable iff (!rst_n) (active_sel != RSTP_SEL_CLK) |=> (debug_test_points_oe_n == RSTP_TP_ALL_OFF);
	endproperty
	a_hiz_mode: assert property (p_hiz_mode) else $error("test points driven outside clock mode");

	property p_clk_mode;
		@(posedge core_clk) disable iff (!rst_n) (capture_done && active_sel == RSTP_SEL_CLK) [*2] |=>
			(debug_test_points_oe_n == RSTP_TP_ALL_ON) && (debug_test_points_out[0] != $past(debug_test_points_out[0]))
			&& (debug_test_points_out[5] == debug_test_points_out[0])
			&& !debug_test_points_out[3] && !debug_test_points_out[6] && !debug_test_points_out[7];
	endproperty
	a_clk_mode: assert property (p_clk_mode) else $error("clock debug outputs wrong");

	property p_sw_override;
		@(posedge core_clk) disable iff (!rst_n) capture_done && sw_sel_wr |=> (active_sel == $past(sw_sel));
	endproperty
	a_sw_override: assert property (p_sw_override) else $error("software selection ignored");

	property p_early_refused;
		@(posedge core_clk) disable iff (!rst_n) !capture_done && !cap_now |=> (active_sel == RSTP_SEL_HIZ);
	endproperty
	a_early_refused: assert property (p_early_refused) else $error("selection changed before capture");
endmodule : rstp_port
`default_nettype wire

// ==== bench/rstp_board.sv ====
// Board model: strap resistors on the debug and selector pins.
// Assumes oe_n low means the port drives the pin.
`timescale 1ns/1ps
`default_nettype none
module rstp_board
	import rstp_pkg::*;
(
	input wire logic [RSTP_TP_W-1:0] tp_strap,
	input wire logic [RSTP_SEL_W-1:0] sel_strap,
	input wire logic [RSTP_TP_W-1:0] tp_out,
	input wire logic [RSTP_TP_W-1:0] tp_oe_n,
	input wire logic [RSTP_SEL_W-1:0] sel_out,
	input wire logic [RSTP_SEL_W-1:0] sel_oe_n,
	output logic [RSTP_TP_W-1:0] tp_pin,
	output logic [RSTP_SEL_W-1:0] sel_pin
);
	// Undriven pins settle at the resistor level
	always_comb tp_pin = (tp_oe_n & tp_strap) | (~tp_oe_n & tp_out);
	always_comb sel_pin = (sel_oe_n & sel_strap) | (~sel_oe_n & sel_out);
endmodule : rstp_board
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the reset-strap test-point port.
// Assumes the board model resolves every pin.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import rstp_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] tp_strap = 8'hA5;
	logic [2:0] sel_strap = 3'h2;
	logic [2:0] jtag_tdo = 3'h5;
	logic sw_sel_wr = 1'b0;
	logic [2:0] sw_sel = 3'h0;
	logic [7:0] tp_pin, tp_out, tp_oe_n, cfg_strap;
	logic [2:0] sel_pin, sel_out, sel_oe_n, strap_sel, active_sel;
	logic capture_done;
	int n_mismatch = 0;
	int num_checks = 0;
	int cycles = 0;
	always #12.5 core_clk = ~core_clk;
	rstp_board rstp_board_i(.tp_strap(tp_strap), .sel_strap(sel_strap), .tp_out(tp_out), .tp_oe_n(tp_oe_n),
		.sel_out(sel_out), .sel_oe_n(sel_oe_n), .tp_pin(tp_pin), .sel_pin(sel_pin));
	rstp_port rstp_port_i(.core_clk(core_clk), .rst_n(rst_n), .debug_test_points_in(tp_pin),
		.debug_test_points_out(tp_out), .debug_test_points_oe_n(tp_oe_n), .test_out_strap_selector_in(sel_pin),
		.test_out_strap_selector_out(sel_out), .test_out_strap_selector_oe_n(sel_oe_n), .jtag_tdo(jtag_tdo),
		.sw_sel_wr(sw_sel_wr), .sw_sel(sw_sel), .cfg_strap(cfg_strap), .strap_sel(strap_sel),
		.active_sel(active_sel), .capture_done(capture_done));
	////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic do_reset(input logic [7:0] tp, input logic [2:0] sel);
		@(posedge core_clk);
		rst_n <= 1'b0;
		tp_strap <= tp;
		sel_strap <= sel;
		repeat (20) @(posedge core_clk);
		#1 check("tp_oe_n in reset", tp_oe_n, 8'hFF);
		@(posedge core_clk);
		rst_n <= 1'b1;
		sw_sel_wr <= 1'b1;
		sw_sel <= RSTP_SEL_CLK;
		repeat (RSTP_CAPTURE_CYC_I - 1) @(posedge core_clk);
		sw_sel_wr <= 1'b0;
		#1 check("done early", {7'h0, capture_done}, 8'h00);
		check("early write refused", {5'h0, active_sel}, {5'h0, RSTP_SEL_HIZ});
		@(posedge core_clk);
		#1 check("done", {7'h0, capture_done}, 8'h01);
		check("cfg_strap", cfg_strap, tp);
		check("strap_sel", {5'h0, strap_sel}, {5'h0, sel});
		check("sel_oe_n", {5'h0, sel_oe_n}, 8'h00);
		check("tp_oe_n at capture", tp_oe_n, 8'hFF);
		tp_strap <= ~tp;
		$display("reset with straps %h %h done", tp, sel);
	endtask : do_reset
	task automatic count_edges(input logic [7:0] exp_oe, input logic [63:0] exp_n);
		logic [7:0] prev;
		logic [7:0] n [8];
		n = '{default: 8'h0};
		@(posedge core_clk);
		#1 prev = tp_out;
		check("tp_oe_n", tp_oe_n, exp_oe);
		repeat (16) begin
			@(posedge core_clk);
			#1 for (int i = 0; i < 8; i++) if (tp_out[i] !== prev[i]) n[i]++;
			prev = tp_out;
		end
		for (int i = 0; i < 8; i++) check("toggles", n[i], exp_n[i*8 +: 8]);
		check("low points", tp_out & 8'hC8, 8'h00);
	endtask : count_edges
	task automatic test_clock_mode();
		do_reset(8'hA5, 3'h2);
		count_edges(8'h00, 64'h00_00_10_04_00_02_08_10);
		check("cfg_strap held", cfg_strap, 8'hA5);
		check("sel_out", {5'h0, sel_out}, {5'h0, jtag_tdo});
		$display("clock mode test done");
	endtask : test_clock_mode
	task automatic test_sw_select();
		logic [2:0] vals [4] = '{3'h7, 3'h5, 3'h2, 3'h0};
		foreach (vals[k]) begin
			@(posedge core_clk);
			sw_sel_wr <= 1'b1;
			sw_sel <= vals[k];
			jtag_tdo <= vals[k];
			@(posedge core_clk);
			sw_sel_wr <= 1'b0;
			#1 check("active_sel", {5'h0, active_sel}, {5'h0, vals[k]});
			check("sel_out follows", {5'h0, sel_out}, {5'h0, vals[k]});
			@(posedge core_clk);
			#1 check("oe after write", tp_oe_n, vals[k] == 3'h2 ? 8'h00 : 8'hFF);
		end
		$display("software select test done");
	endtask : test_sw_select
	task automatic test_hiz_straps();
		do_reset(8'h3C, 3'h7);
		count_edges(8'hFF, 64'h0);
		do_reset(8'hC3, 3'h5);
		count_edges(8'hFF, 64'h0);
		$display("hi-z strap test done");
	endtask : test_hiz_straps
	initial begin
		test_clock_mode();
		test_sw_select();
		test_hiz_straps();
		final_report();
	end
endmodule : testbench
`default_nettype wire
